//--- tcc_pkg.sv
package tcc_pkg;
  // ****************************************
  // Register map (byte-wide bus, word regs split in hi/lo bytes)
  // ****************************************
  localparam logic [3:0] ADDR_CNT_HI = 4'h0;
  localparam logic [3:0] ADDR_CNT_LO = 4'h1;
  localparam logic [3:0] ADDR_GRA_HI = 4'h2;
  localparam logic [3:0] ADDR_GRA_LO = 4'h3;
  localparam logic [3:0] ADDR_GRB_HI = 4'h4;
  localparam logic [3:0] ADDR_GRB_LO = 4'h5;
  localparam logic [3:0] ADDR_BRA_HI = 4'h6;
  localparam logic [3:0] ADDR_BRA_LO = 4'h7;
  localparam logic [3:0] ADDR_CTRL = 4'h8;
  localparam logic [3:0] ADDR_STAT = 4'h9;
  localparam logic [3:0] ADDR_CNT_W = 4'hA;
  // ****************************************
  // Control fields
  // ****************************************
  localparam int CTL_CLR_LO = 0;
  localparam int CTL_CLR_HI = 1;
  localparam int CTL_A_CAP = 2;
  localparam int CTL_B_CAP = 3;
  localparam int CTL_PWM = 4;
  localparam int CTL_SYNC = 5;
  localparam int CTL_BUF = 6;
  localparam int CTL_RUN = 7;
  localparam int ST_FLAG_A = 0;
  localparam int ST_FLAG_B = 1;
  localparam int ST_WRAP = 2;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] GR_RST = 16'hFFFF;
  localparam logic [15:0] CNT_ONES = 16'hFFFF;
  localparam logic [1:0] BUS_T1 = 2'h1;
  localparam logic [1:0] BUS_T2 = 2'h2;
  localparam logic [1:0] BUS_T3 = 2'h3;
  typedef enum logic [1:0] {BUS_IDLE, BUS_S1, BUS_S2, BUS_S3} tcc_bus_type;
endpackage

//--- tcc_channel.sv
// Overview of operation
// - Clear beats counter write in third state
// - Word write beats increment in third state
// - Byte write beats increment, other byte kept
// - Match register write suppresses compare match
// - Write beats wrap counting, wrap flag set
// - Read during capture returns old value
// - Capture-clear stores pre-clear count, no increment
// - Capture beats match register write
// - Match clear gives period of N plus one
// - Capture beats buffer write when buffering
// - Synchronized byte write loads all counters
// - PWM disables capture, A+B match suppressed
// - Clear field picks A, B or sync clear
// - A-capture select bit picks capture or compare
// - Sync preset and clear need sync enable
// - Wrap flag on FFFF to 0000 rollover
// - Flag clears on read-while-set then zero write
module tcc_channel
  import tcc_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic clk_i, // System clock
  input wire logic arst_n_i, // Async reset, active low
  input wire logic clk_en_i, // Freezes all state when low
  input wire logic [3:0] addr_i, // Register address
  input wire logic [7:0] wdata_i, // Write data byte
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [7:0] rdata_o, // Read data, registered at end of third bus state
  input wire logic inc_i, // Timer increment pulse
  input wire logic cap_a_i, // Capture edge on A
  input wire logic cap_b_i, // Capture edge on B
  input wire logic sync_clr_i, // Clear from synced channels
  input wire logic sync_load_i, // Preset from synced channels
  input wire logic [WIDTH-1:0] sync_val_i, // Preset value
  output logic sync_clr_o, // This channel clears, to peers
  output logic sync_load_o, // This channel preset, to peers
  output logic [WIDTH-1:0] sync_val_o, // Preset value to peers
  output logic match_a_o, // Compare match A pulse
  output logic match_b_o, // Compare match B pulse
  output logic [2:0] flags_o // Status flags A, B, wrap
);
  // ****************************************
  // Bus cycle sequencer
  // ****************************************
  // Strobe starts a cycle; data commits in its third state.
  tcc_bus_type bus_st;
  logic [3:0] bus_addr;
  logic [7:0] bus_data;
  logic bus_wr;
  logic bus_busy;
  logic [WIDTH-1:0] cnt;
  logic [WIDTH-1:0] gra;
  logic [WIDTH-1:0] grb;
  logic [WIDTH-1:0] bra;
  logic [7:0] ctrl;
  logic [2:0] flags;
  logic [2:0] flag_seen;

  function automatic logic [WIDTH-1:0] put_byte(input logic [WIDTH-1:0] v, input logic hi,
                                                input logic [7:0] b);
    put_byte = hi ? {b, v[7:0]} : {v[WIDTH-1:8], b};
  endfunction

  function automatic logic [7:0] get_byte(input logic [WIDTH-1:0] v, input logic hi);
    get_byte = hi ? v[WIDTH-1:8] : v[7:0];
  endfunction

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_st <= BUS_IDLE;
      bus_addr <= 4'h0;
      bus_data <= 8'h00;
      bus_wr <= 1'b0;
    end else if (clk_en_i) begin
      case (bus_st)
        BUS_IDLE: if (wr_i || rd_i) begin
          bus_st <= BUS_S2;
          bus_addr <= addr_i;
          bus_data <= wdata_i;
          bus_wr <= wr_i;
        end
        BUS_S2: bus_st <= BUS_S3;
        default: bus_st <= BUS_IDLE;
      endcase
    end
  end

  // Strobes arriving while busy are dropped; the host never stalls.
  assign bus_busy = (bus_st != BUS_IDLE);
  wire t2 = (bus_st == BUS_S2);
  wire t3 = (bus_st == BUS_S3);
  wire w3 = t3 && bus_wr;
  wire r3 = t3 && !bus_wr;
  wire a_hi = !bus_addr[0];
  wire wr_cnt_word = w3 && (bus_addr == ADDR_CNT_W);
  wire wr_cnt_byte = bus_wr && (t2 || t3) && (bus_addr == ADDR_CNT_HI || bus_addr == ADDR_CNT_LO);
  wire wr_cnt_byte3 = w3 && (bus_addr == ADDR_CNT_HI || bus_addr == ADDR_CNT_LO);
  wire wr_gra = w3 && (bus_addr == ADDR_GRA_HI || bus_addr == ADDR_GRA_LO);
  wire wr_grb = w3 && (bus_addr == ADDR_GRB_HI || bus_addr == ADDR_GRB_LO);
  wire wr_bra = w3 && (bus_addr == ADDR_BRA_HI || bus_addr == ADDR_BRA_LO);
  wire wr_ctrl = w3 && (bus_addr == ADDR_CTRL);
  wire wr_stat = w3 && (bus_addr == ADDR_STAT);
  wire rd_stat = r3 && (bus_addr == ADDR_STAT);

  // ****************************************
  // Mode decode
  // ****************************************
  wire pwm_on = ctrl[CTL_PWM];
  wire sync_on = ctrl[CTL_SYNC];
  wire run = ctrl[CTL_RUN];
  wire a_is_cap = !pwm_on && ctrl[CTL_A_CAP];
  wire b_is_cap = !pwm_on && ctrl[CTL_B_CAP];
  wire step = run && inc_i;
  wire cap_a = a_is_cap && cap_a_i;
  wire cap_b = b_is_cap && cap_b_i;
  // Match fires as count leaves N
  wire eq_a = !a_is_cap && (cnt == gra) && step;
  wire eq_b = !b_is_cap && (cnt == grb) && step;
  // simultaneous A and B inhibited in PWM
  wire pwm_both = pwm_on && eq_a && eq_b;
  // write to the register inhibits its match
  wire cm_a = eq_a && !wr_gra && !pwm_both;
  wire cm_b = eq_b && !wr_grb && !pwm_both;
  wire ev_a = cm_a || cap_a;
  wire ev_b = cm_b || cap_b;
  wire [1:0] clr_sel = {ctrl[CTL_CLR_HI], ctrl[CTL_CLR_LO]};
  wire own_clr = (clr_sel == 2'b01 && ev_a) || (clr_sel == 2'b10 && ev_b);
  wire peer_clr = sync_on && clr_sel == 2'b11 && sync_clr_i;
  wire clr = own_clr || peer_clr;
  wire cpu_cnt_wr = wr_cnt_word || wr_cnt_byte3;
  // byte write forms full 16-bit value
  wire [WIDTH-1:0] cnt_wval = wr_cnt_word ? {bus_data, bus_data} & CNT_ONES :
                              put_byte(cnt, a_hi, bus_data);
  wire peer_load = sync_on && sync_load_i;
  wire wrap = step && (cnt == CNT_ONES);

  logic [WIDTH-1:0] next_cnt;
  always_comb begin
    next_cnt = cnt;
    if (clr) begin
      next_cnt = CNT_RST;
    end else if (cpu_cnt_wr) begin
      next_cnt = cnt_wval;
    end else if (peer_load) begin
      next_cnt = sync_val_i;
    end else if (wr_cnt_byte) begin
      // T2 of byte write holds count
      next_cnt = cnt;
    end else if (step) begin
      next_cnt = cnt + 16'h0001;
    end
  end

  // ****************************************
  // Counter and general registers
  // ****************************************
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt <= CNT_RST;
      ctrl <= CTRL_RST;
    end else if (clk_en_i) begin
      cnt <= next_cnt;
      if (wr_ctrl) begin
        ctrl <= bus_data;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gra <= GR_RST;
      grb <= GR_RST;
      bra <= GR_RST;
    end else if (clk_en_i) begin
      if (cap_a) begin
        gra <= cnt;
      end else if (wr_gra) begin
        gra <= put_byte(gra, a_hi, bus_data);
      end
      if (cap_b) begin
        grb <= cnt;
      end else if (wr_grb) begin
        grb <= put_byte(grb, a_hi, bus_data);
      end
      if (cap_a && ctrl[CTL_BUF]) begin
        bra <= gra;
      end else if (wr_bra && !(cap_a && ctrl[CTL_BUF])) begin
        bra <= put_byte(bra, a_hi, bus_data);
      end
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  wire [2:0] flag_set = {wrap, ev_b, ev_a};
  wire [2:0] flag_clr = {3{wr_stat}} & ~bus_data[2:0] & flag_seen;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flags <= 3'h0;
      flag_seen <= 3'h0;
    end else if (clk_en_i) begin
      // wrap flag still set on write
      flags <= flag_set | (flags & ~flag_clr);
      if (rd_stat) begin
        flag_seen <= flags;
      end else if (wr_stat) begin
        flag_seen <= 3'h0;
      end
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  // sampled before capture lands
  wire [7:0] rd_mux =
    (bus_addr == ADDR_CNT_HI || bus_addr == ADDR_CNT_LO) ? get_byte(cnt, a_hi) :
    (bus_addr == ADDR_GRA_HI || bus_addr == ADDR_GRA_LO) ? get_byte(gra, a_hi) :
    (bus_addr == ADDR_GRB_HI || bus_addr == ADDR_GRB_LO) ? get_byte(grb, a_hi) :
    (bus_addr == ADDR_BRA_HI || bus_addr == ADDR_BRA_LO) ? get_byte(bra, a_hi) :
    (bus_addr == ADDR_CTRL) ? ctrl :
    (bus_addr == ADDR_STAT) ? {5'h00, flags} : 8'h00;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 8'h00;
      match_a_o <= 1'b0;
      match_b_o <= 1'b0;
      sync_clr_o <= 1'b0;
      sync_load_o <= 1'b0;
      sync_val_o <= CNT_RST;
      flags_o <= 3'h0;
    end else if (clk_en_i) begin
      rdata_o <= r3 ? rd_mux : 8'h00;
      match_a_o <= cm_a;
      match_b_o <= cm_b;
      sync_clr_o <= sync_on && own_clr;
      sync_load_o <= sync_on && cpu_cnt_wr && !clr;
      sync_val_o <= cnt_wval;
      flags_o <= flag_set | (flags & ~flag_clr);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_wr_start;
    clk_en_i && !bus_busy && wr_i;
  endsequence

  chk_clear_beats_write: assert property (clk_en_i && clr |=> cnt == CNT_RST)
    else $error("clear did not win");
  chk_word_write_wins: assert property (clk_en_i && wr_cnt_word && !clr |=> cnt == $past(cnt_wval))
    else $error("word write lost");
  chk_byte_hold: assert property (clk_en_i && t2 && wr_cnt_byte && !clr && !peer_load |=> cnt == $past(cnt))
    else $error("increment not held off");
  chk_match_inhibit: assert property (wr_gra |-> !cm_a)
    else $error("match not inhibited");
  chk_wrap_on_write: assert property (clk_en_i && wrap |=> flags[ST_WRAP])
    else $error("wrap flag missing");
  chk_capture_store: assert property (clk_en_i && cap_a |=> gra == $past(cnt))
    else $error("capture not stored");
  chk_pwm_no_cap: assert property (pwm_on |-> !cap_a && !cap_b)
    else $error("capture in pwm");
  chk_flag_clear_rule: assert property (clk_en_i && flags[ST_WRAP] && !flag_seen[ST_WRAP] && !wrap
                                        |=> flags[ST_WRAP])
    else $error("flag cleared without read");
  chk_cycle_three: assert property (s_wr_start |=> t2 ##1 (t3 || !clk_en_i))
    else $error("bus cycle length wrong");
endmodule

//--- tcc_pin_model.sv
module tcc_pin_model (
  input wire logic clk_i, // System clock
  input wire logic arst_n_i, // Async reset, active low
  input wire logic [2:0] fire_i, // Request: bit0 inc, bit1 capture A, bit2 peer clear
  output logic inc_o, // Timer increment pulse
  output logic cap_a_o, // Capture edge on A
  output logic clr_o // Clear from a synced peer
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********************
  // Pin events
  // ********************
  // Registered, so each event lands one cycle after its request
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {clr_o, cap_a_o, inc_o} <= 3'h0;
    end else begin
      {clr_o, cap_a_o, inc_o} <= fire_i;
    end
  end
endmodule

//--- timer_channel_contention_logic_tb.sv
module timer_channel_contention_logic_tb
  import tcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [2:0] F_INC = 3'h1;
  localparam logic [2:0] F_CAP = 3'h2;
  localparam logic [2:0] F_CLR = 3'h4;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [2:0] fire = 3'h0;
  logic inc_i, cap_a_i, sync_clr_i, sync_load_o, match_a_o;
  logic [7:0] rdata_o;
  logic [15:0] sync_val_o;
  logic [2:0] flags_o;
  logic [15:0] last_load = 16'h0000;
  logic saw_match = 1'b0;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;

  always #20 clk_i = ~clk_i;

  tcc_pin_model pins_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .fire_i(fire),
    .inc_o(inc_i), .cap_a_o(cap_a_i), .clr_o(sync_clr_i));

  tcc_channel #(.WIDTH(16)) dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .clk_en_i(1'b1),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .inc_i(inc_i), .cap_a_i(cap_a_i), .cap_b_i(1'b0), .sync_clr_i(sync_clr_i),
    .sync_load_i(1'b0), .sync_val_i(16'h0000), .sync_clr_o(), .sync_load_o(sync_load_o),
    .sync_val_o(sync_val_o), .match_a_o(match_a_o), .match_b_o(), .flags_o(flags_o));

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (sync_load_o === 1'b1) last_load <= sync_val_o;
    if (match_a_o === 1'b1) saw_match <= 1'b1;
    if (cycles == 3000) begin
      err_count++;
      give_verdict();
    end
  end

  // ********************
  // Bus and check tasks
  // ********************
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Pin events requested here land in the third bus state
  task automatic acc(input logic wr, input logic [3:0] a, input logic [7:0] d,
                     input logic [2:0] f, output logic [7:0] q);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= wr;
    rd_i <= !wr;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    fire <= f;
    @(posedge clk_i);
    fire <= 3'h0;
    @(posedge clk_i);
    @(negedge clk_i);
    q = rdata_o;
  endtask

  task automatic wr8(input logic [3:0] a, input logic [7:0] d, input logic [2:0] f);
    logic [7:0] q;
    acc(1'b1, a, d, f, q);
  endtask

  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    acc(1'b0, a, 8'h00, 3'h0, v[15:8]);
    acc(1'b0, a + 4'h1, 8'h00, 3'h0, v[7:0]);
  endtask

  task automatic pins(input logic [2:0] f, input int n);
    @(posedge clk_i);
    fire <= f;
    repeat (n) @(posedge clk_i);
    fire <= 3'h0;
    repeat (2) @(posedge clk_i);
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic t_reset();
    logic [15:0] v;
    rd16(ADDR_CNT_HI, v);
    chk("counter", CNT_RST, v); // reset value
    rd16(ADDR_GRA_HI, v);
    chk("match A", GR_RST, v); // reset value
    $display("test reset finished");
  endtask

  task automatic t_write_inc();
    logic [15:0] v;
    wr8(ADDR_CTRL, 8'h80, 3'h0);
    wr8(ADDR_CNT_W, 8'h12, F_INC);
    rd16(ADDR_CNT_HI, v);
    chk("word write", 16'h1212, v); // write wins
    wr8(ADDR_CNT_HI, 8'h34, F_INC);
    rd16(ADDR_CNT_HI, v);
    chk("byte write", 16'h3412, v); // write wins
    pins(F_INC, 1);
    rd16(ADDR_CNT_HI, v);
    chk("increment", 16'h3413, v); // counts when idle
    $display("test write against increment finished");
  endtask

  task automatic t_wrap();
    logic [15:0] v;
    logic [7:0] q;
    wr8(ADDR_CNT_W, 8'hFF, 3'h0);
    wr8(ADDR_CNT_W, 8'h05, F_INC);
    rd16(ADDR_CNT_HI, v);
    chk("wrap write", 16'h0505, v); // write wins
    chk("wrap flag", 16'h0001, {15'h0, flags_o[2]}); // still set
    acc(1'b0, ADDR_STAT, 8'h00, 3'h0, q);
    chk("status read", 16'h0001, {15'h0, q[2]}); // read while set
    wr8(ADDR_STAT, 8'h00, 3'h0);
    chk("flag clear", 16'h0000, {15'h0, flags_o[2]}); // then zero
    wr8(ADDR_CNT_W, 8'hFF, 3'h0);
    pins(F_INC, 1);
    chk("rollover flag", 16'h0001, {15'h0, flags_o[2]}); // all ones to zero
    rd16(ADDR_CNT_HI, v);
    chk("rollover", 16'h0000, v); // all ones to zero
    $display("test wrap finished");
  endtask

  task automatic t_clear();
    logic [15:0] v;
    wr8(ADDR_CTRL, 8'h83, 3'h0);
    wr8(ADDR_CNT_W, 8'h21, 3'h0);
    pins(F_CLR, 1);
    rd16(ADDR_CNT_HI, v);
    chk("unsynced clear", 16'h2121, v); // needs enable
    wr8(ADDR_CTRL, 8'hA3, 3'h0);
    wr8(ADDR_CNT_W, 8'h77, F_CLR);
    rd16(ADDR_CNT_HI, v);
    chk("clear on write", 16'h0000, v); // clear wins
    wr8(ADDR_CNT_W, 8'h12, 3'h0);
    wr8(ADDR_CNT_LO, 8'h56, 3'h0);
    @(negedge clk_i);
    chk("preset value", 16'h1256, last_load); // full word
    $display("test clear and preset finished");
  endtask

  task automatic t_capture();
    logic [15:0] v;
    logic [7:0] q;
    wr8(ADDR_CTRL, 8'h85, 3'h0);
    wr8(ADDR_CNT_W, 8'h42, 3'h0);
    wr8(ADDR_GRA_HI, 8'h99, F_CAP);
    rd16(ADDR_GRA_HI, v);
    chk("capture on write", 16'h4242, v); // capture wins
    wr8(ADDR_CNT_W, 8'h55, 3'h0);
    acc(1'b0, ADDR_GRA_HI, 8'h00, F_CAP, q);
    chk("read in capture", 16'h0042, {8'h00, q}); // old value
    wr8(ADDR_CNT_W, 8'h10, 3'h0);
    pins(F_CAP | F_INC, 1);
    rd16(ADDR_GRA_HI, v);
    chk("pre-clear count", 16'h1010, v); // captured
    rd16(ADDR_CNT_HI, v);
    chk("cleared counter", 16'h0000, v); // no increment
    wr8(ADDR_CTRL, 8'hC4, 3'h0);
    wr8(ADDR_BRA_HI, 8'h66, F_CAP);
    rd16(ADDR_BRA_HI, v);
    chk("buffer on write", 16'h1010, v); // capture wins
    $display("test capture finished");
  endtask

  task automatic t_period();
    logic [15:0] v;
    wr8(ADDR_CTRL, 8'h81, 3'h0);
    wr8(ADDR_GRA_HI, 8'h00, 3'h0);
    wr8(ADDR_GRA_LO, 8'h03, 3'h0);
    wr8(ADDR_CNT_W, 8'h00, 3'h0);
    saw_match = 1'b0;
    pins(F_INC, 3);
    rd16(ADDR_CNT_HI, v);
    chk("at match", 16'h0003, v); // holds N
    chk("no early match", 16'h0000, {15'h0, saw_match}); // fires on leaving
    wr8(ADDR_GRA_LO, 8'h03, F_INC);
    rd16(ADDR_CNT_HI, v);
    chk("match on write", 16'h0004, v); // match inhibited
    chk("no match on write", 16'h0000, {15'h0, saw_match}); // inhibited
    wr8(ADDR_CNT_LO, 8'h03, 3'h0);
    pins(F_INC, 1);
    rd16(ADDR_CNT_HI, v);
    chk("period end", 16'h0000, v); // N plus one
    chk("match seen", 16'h0001, {15'h0, saw_match}); // fires on leaving
    wr8(ADDR_CTRL, 8'h01, 3'h0);
    wr8(ADDR_CTRL, 8'h94, 3'h0);
    pins(F_CAP, 1);
    rd16(ADDR_GRA_HI, v);
    chk("pwm capture", 16'h0003, v); // capture off
    $display("test period and pwm finished");
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_reset();
    t_write_inc();
    t_wrap();
    t_clear();
    t_capture();
    t_period();
    give_verdict();
  end
endmodule
